/* awc_pkg.sv */
// Package for the write and standby command decoder: opcodes, status bits, sizes.
// Assumes a single device clock; shared by the decoder, its checker and the bench.
package awc_pkg;
  localparam logic [7:0] OP_STANDBY_NOW = 8'hE0;
  localparam logic [7:0] OP_WRITE_BUF   = 8'hE8;
  localparam logic [7:0] OP_WRITE_DMA_A = 8'hCA;
  localparam logic [7:0] OP_WRITE_DMA_B = 8'hCB;
  localparam logic [7:0] OP_WRITE_DMA_X = 8'h35;
  localparam logic [7:0] OP_WRITE_MULT  = 8'hC5;
  localparam logic [7:0] OP_WRITE_MULTX = 8'h39;
  localparam logic [7:0] OP_WRITE_SECT  = 8'h30;
  localparam logic [7:0] OP_WRITE_SECTX = 8'h34;
  localparam logic [7:0] OP_WRITE_NOERS = 8'h38;
  localparam logic [7:0] OP_WRITE_VFY   = 8'h3C;
  localparam logic [7:0] OP_SET_MULT    = 8'hC6;
  localparam logic [7:0] OP_SET_MAX     = 8'hF9;
  localparam logic [7:0] OP_SET_MAX_X   = 8'h37;
  localparam int         LBA_W          = 48;
  localparam int         CNT_W          = 17;
  localparam logic [16:0] CNT_256       = 17'h00100;
  localparam logic [16:0] CNT_65536     = 17'h10000;
  localparam logic [7:0] MULT_RESET     = 8'h01;
  localparam logic [7:0] ERR_ABORT      = 8'h04;
  localparam logic [7:0] ERR_IDNF       = 8'h10;
  localparam int         WORDS_PER_SECT = 256;
  localparam int         FIFO_DEPTH     = 4;
  typedef enum logic [2:0] {
    AWC_IDLE, AWC_STANDBY, AWC_XFER, AWC_VERIFY, AWC_DONE
  } awc_state_e;
endpackage : awc_pkg

/* awc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/1ps
`default_nettype none
module awc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             push;
  logic             pop;
  assign in_ready  = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign out_valid = (wp_r != rp_r);
  assign out_data  = mem[rp_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop)  rp_r <= rp_r + 1'b1;
    end
  end
endmodule : awc_fifo
`default_nettype wire

/* awc_decoder.sv */
// Command decoder for the write-family, buffer-write and standby commands.
// Assumes taskfile values are stable while cmd_valid is high, same clock.
// Functional notes
// - Opcode E0h is the immediate standby command.
// - Standby sets busy, enters standby, clears busy, interrupts at once.
// - E8h takes one sector and replaces the sector buffer contents.
// - CAh and CBh start DMA writes of 1 to 256 sectors.
// - For 28-bit writes a count of zero means 256 sectors.
// - 35h starts an extended DMA write of 1 to 65536 sectors.
// - For extended writes a count of zero means 65536 sectors.
// - Writes start at the given sector address and advance sequentially.
// - C5h writes by PIO in blocks sized by the last set-multiple.
// - Multiple writes interrupt once per block, not per sector.
// - 39h is the multiple write with extended addressing and count.
// - 30h is a PIO write of 1 to 256 sectors, interrupt per sector.
// - 34h is a PIO write of 1 to 65536 sectors, extended addressing.
// - 38h writes like the ordinary sector write.
// - 3Ch writes and verifies each sector before completion.
// - C6h stores the block count used by later multiple writes.
// - Writes beyond a set maximum address fail with an IDNF error.
`timescale 1ns/1ps
`default_nettype none
module awc_decoder
  import awc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  wire logic [7:0]        cmd_opcode,
  input  wire logic [15:0]       cmd_count,
  input  wire logic [LBA_W-1:0]  cmd_lba,
  input  wire logic [DATA_W-1:0] host_data,
  input  wire logic              host_valid,
  output logic                   host_ready,
  output logic                   busy,
  output logic                   drq,
  output logic                   dma_mode,
  output logic                   irq,
  output logic                   err,
  output logic [7:0]             err_code,
  output logic                   standby,
  output logic                   media_we,
  output logic [LBA_W-1:0]       media_lba,
  output logic [DATA_W-1:0]      media_data,
  output logic                   buf_we,
  output logic [7:0]             buf_addr,
  output logic [DATA_W-1:0]      buf_data,
  output logic                   vfy_req,
  input  wire logic              vfy_ok
);
  initial begin
    if (DATA_W < 1) $error("DATA_W must be positive");
  end

  awc_state_e       state_r;
  logic [CNT_W-1:0] left_r;
  logic [7:0]       mult_r;
  logic [7:0]       blk_left_r;
  logic [7:0]       word_r;
  logic [LBA_W-1:0] lba_r;
  logic [LBA_W-1:0] max_lba_r;
  logic             max_set_r;
  logic             is_buf_r;
  logic             is_mult_r;
  logic             is_vfy_r;
  logic             is_dma_r;
  logic             host_ready_r;
  logic             busy_r;
  logic             drq_r;
  logic             irq_r;
  logic             err_r;
  logic [7:0]       err_code_r;
  logic             standby_r;
  logic             media_we_r;
  logic             buf_we_r;
  logic             vfy_req_r;
  logic [DATA_W-1:0] f_data;
  logic             f_valid;
  logic             f_ready;
  logic             f_in_ready;
  logic             word_push;
  logic [8:0]       in_cnt_r;

  // Words are staged in the FIFO so a verify stall between sectors pushes back to the host.
  awc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_data   (host_data),
    .in_valid  (word_push),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // The FIFO drains only in transfer; verify stalls it between sectors.
  assign f_ready = (state_r == AWC_XFER);
  // A word is taken exactly when the host sees ready, never on valid alone.
  assign word_push = host_valid && host_ready_r;

  logic             w28;
  logic             wext;
  logic             known_write;
  logic [CNT_W-1:0] cnt_dec;
  logic [LBA_W-1:0] last_lba;
  always_comb begin
    w28  = (cmd_opcode == OP_WRITE_DMA_A) || (cmd_opcode == OP_WRITE_DMA_B)
        || (cmd_opcode == OP_WRITE_MULT) || (cmd_opcode == OP_WRITE_SECT)
        || (cmd_opcode == OP_WRITE_NOERS) || (cmd_opcode == OP_WRITE_VFY);
    wext = (cmd_opcode == OP_WRITE_DMA_X) || (cmd_opcode == OP_WRITE_MULTX)
        || (cmd_opcode == OP_WRITE_SECTX);
    known_write = w28 || wext;
    if (w28) begin
      cnt_dec = (cmd_count[7:0] == 8'h00) ? CNT_256 : {9'h000, cmd_count[7:0]};
    end else begin
      cnt_dec = (cmd_count == 16'h0000) ? CNT_65536 : {1'b0, cmd_count};
    end
    last_lba = cmd_lba + LBA_W'(cnt_dec) - 1'b1;
  end

  logic word_take;
  logic sect_end;
  assign word_take = f_valid && f_ready;
  assign sect_end  = word_take && (word_r == 8'(WORDS_PER_SECT - 1));

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r      <= AWC_IDLE;
      busy_r       <= 1'b0;
      drq_r        <= 1'b0;
      irq_r        <= 1'b0;
      err_r        <= 1'b0;
      err_code_r   <= 8'h00;
      left_r       <= '0;
      blk_left_r   <= 8'h00;
      word_r       <= 8'h00;
      lba_r        <= '0;
      is_buf_r     <= 1'b0;
      is_mult_r    <= 1'b0;
      is_vfy_r     <= 1'b0;
      is_dma_r     <= 1'b0;
      vfy_req_r    <= 1'b0;
    end else begin
      irq_r     <= 1'b0;
      vfy_req_r <= 1'b0;
      case (state_r)
        AWC_IDLE: begin
          if (cmd_valid) begin
            err_r      <= 1'b0;
            err_code_r <= 8'h00;
            busy_r     <= 1'b1;
            is_buf_r   <= 1'b0;
            is_mult_r  <= (cmd_opcode == OP_WRITE_MULT) || (cmd_opcode == OP_WRITE_MULTX);
            is_vfy_r   <= (cmd_opcode == OP_WRITE_VFY);
            is_dma_r   <= (cmd_opcode == OP_WRITE_DMA_A) || (cmd_opcode == OP_WRITE_DMA_B)
                       || (cmd_opcode == OP_WRITE_DMA_X);
            lba_r      <= cmd_lba;
            left_r     <= cnt_dec;
            blk_left_r <= mult_r;
            word_r     <= 8'h00;
            if (cmd_opcode == OP_STANDBY_NOW) begin
              state_r <= AWC_STANDBY;
            end else if (cmd_opcode == OP_WRITE_BUF) begin
              is_buf_r <= 1'b1;
              left_r   <= CNT_W'(1);
              drq_r    <= 1'b1;
              state_r  <= AWC_XFER;
            end else if (cmd_opcode == OP_SET_MULT || cmd_opcode == OP_SET_MAX
                         || cmd_opcode == OP_SET_MAX_X) begin
              state_r <= AWC_DONE;
            end else if (known_write) begin
              if (max_set_r && (last_lba > max_lba_r)) begin
                err_r      <= 1'b1;
                err_code_r <= ERR_IDNF;
                state_r    <= AWC_DONE;
              end else begin
                drq_r   <= 1'b1;
                state_r <= AWC_XFER;
              end
            end else begin
              err_r      <= 1'b1;
              err_code_r <= ERR_ABORT;
              state_r    <= AWC_DONE;
            end
          end
        end
        AWC_STANDBY: begin
          busy_r  <= 1'b0;
          irq_r   <= 1'b1;
          state_r <= AWC_IDLE;
        end
        AWC_XFER: begin
          if (word_take) begin
            word_r <= word_r + 8'h01;
          end
          if (sect_end) begin
            lba_r  <= lba_r + 1'b1;
            left_r <= left_r - 1'b1;
            if (is_vfy_r) begin
              drq_r     <= 1'b0;
              vfy_req_r <= 1'b1;
              state_r   <= AWC_VERIFY;
            end else if (left_r == CNT_W'(1)) begin
              drq_r   <= 1'b0;
              state_r <= AWC_DONE;
            end else if (is_mult_r) begin
              blk_left_r <= blk_left_r - 8'h01;
              if (blk_left_r == 8'h01) begin
                blk_left_r <= mult_r;
                irq_r      <= 1'b1;
              end
            end else if (!is_dma_r) begin
              irq_r <= 1'b1;
            end
          end
        end
        AWC_VERIFY: begin
          if (vfy_ok) begin
            if (left_r == '0) begin
              state_r <= AWC_DONE;
            end else begin
              drq_r   <= 1'b1;
              irq_r   <= 1'b1;
              state_r <= AWC_XFER;
            end
          end
        end
        AWC_DONE: begin
          busy_r  <= 1'b0;
          irq_r   <= 1'b1;
          state_r <= AWC_IDLE;
        end
        default: begin
          state_r <= AWC_IDLE;
        end
      endcase
    end
  end

  // Block size and maximum address persist across commands until reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      mult_r    <= MULT_RESET;
      max_set_r <= 1'b0;
      max_lba_r <= '0;
    end else if (state_r == AWC_IDLE && cmd_valid) begin
      if (cmd_opcode == OP_SET_MULT && cmd_count[7:0] != 8'h00) begin
        mult_r <= cmd_count[7:0];
      end
      if (cmd_opcode == OP_SET_MAX || cmd_opcode == OP_SET_MAX_X) begin
        max_set_r <= 1'b1;
        max_lba_r <= cmd_lba;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      standby_r <= 1'b0;
    end else if (state_r == AWC_IDLE && cmd_valid) begin
      standby_r <= (cmd_opcode == OP_STANDBY_NOW);
    end
  end

  // Data path: every FIFO word goes to the buffer or media port, registered.
  always_ff @(posedge clock) begin
    if (rst) begin
      media_we_r   <= 1'b0;
      buf_we_r     <= 1'b0;
      media_lba    <= '0;
      media_data   <= '0;
      buf_addr     <= 8'h00;
      buf_data     <= '0;
    end else begin
      media_we_r   <= word_take && !is_buf_r;
      buf_we_r     <= word_take && is_buf_r;
      media_lba    <= lba_r;
      media_data   <= f_data;
      buf_addr     <= word_r;
      buf_data     <= f_data;
    end
  end

  // Ready is a flop, so it cannot see the last word of a sector go by in time.
  // Counting the words accepted for the current sector drops it one edge early,
  // which costs a short gap between sectors but never takes a word past the command.
  always_ff @(posedge clock) begin
    if (rst) begin
      in_cnt_r     <= 9'h000;
      host_ready_r <= 1'b0;
    end else if (state_r != AWC_XFER || sect_end) begin
      in_cnt_r     <= 9'h000;
      host_ready_r <= 1'b0;
    end else begin
      in_cnt_r     <= in_cnt_r + 9'(word_push);
      host_ready_r <= f_in_ready && ((in_cnt_r + 9'(word_push)) < 9'(WORDS_PER_SECT));
    end
  end

  assign host_ready = host_ready_r;
  assign busy       = busy_r;
  assign drq        = drq_r;
  assign dma_mode   = is_dma_r;
  assign irq        = irq_r;
  assign err        = err_r;
  assign err_code   = err_code_r;
  assign standby    = standby_r;
  assign media_we   = media_we_r;
  assign buf_we     = buf_we_r;
  assign vfy_req    = vfy_req_r;
endmodule : awc_decoder
`default_nettype wire

/* awc_decoder_monitor.sv */
// Checker for the command decoder: busy, interrupt, error and address relations.
// Bound to every awc_decoder instance and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module awc_decoder_monitor
  import awc_pkg::*;
(
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             cmd_valid,
  input wire logic [7:0]       cmd_opcode,
  input wire logic [LBA_W-1:0] cmd_lba,
  input wire logic             busy,
  input wire logic             drq,
  input wire logic             irq,
  input wire logic             err,
  input wire logic [7:0]       err_code,
  input wire logic             standby,
  input wire logic             media_we,
  input wire logic [LBA_W-1:0] media_lba,
  input wire logic             buf_we
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic             take;
  logic             known;
  logic             is_wr;
  logic             max_set_r;
  logic             seen_r;
  logic [LBA_W-1:0] max_r;
  logic [LBA_W-1:0] last_r;
  assign take  = cmd_valid && !busy;
  assign is_wr = cmd_opcode inside {OP_WRITE_DMA_A, OP_WRITE_DMA_B, OP_WRITE_DMA_X,
    OP_WRITE_MULT, OP_WRITE_MULTX, OP_WRITE_SECT, OP_WRITE_SECTX, OP_WRITE_NOERS, OP_WRITE_VFY};
  assign known = is_wr || (cmd_opcode inside {OP_STANDBY_NOW, OP_WRITE_BUF, OP_SET_MULT,
    OP_SET_MAX, OP_SET_MAX_X});
  always_ff @(posedge clock) begin
    if (rst) max_set_r <= 1'h0;
    else if (take && (cmd_opcode == OP_SET_MAX || cmd_opcode == OP_SET_MAX_X)) begin
      max_set_r <= 1'h1;
      max_r     <= cmd_lba;
    end
  end
  // The address chain restarts with each command, so only writes within one are compared.
  always_ff @(posedge clock) begin
    if (rst || take) seen_r <= 1'h0;
    else if (media_we) seen_r <= 1'h1;
    if (media_we) last_r <= media_lba;
  end
  a_busy_on_take: assert property (take |=> busy)
    else $error("busy did not rise after a command");
  a_standby_done: assert property (take && cmd_opcode == OP_STANDBY_NOW |=> busy ##1 (!busy && irq && standby))
    else $error("standby did not finish with an interrupt");
  a_abort_code: assert property (take && !known |-> ##2 (irq && !busy && err && err_code == ERR_ABORT))
    else $error("unknown opcode not aborted");
  a_abort_no_data: assert property (take && !known |=> (!drq && !media_we) [*3])
    else $error("aborted command moved data");
  a_idnf_reject: assert property (take && is_wr && max_set_r && cmd_lba > max_r |-> ##2 (irq && err && err_code == ERR_IDNF))
    else $error("write past the maximum address not rejected");
  a_lba_advance: assert property (media_we && seen_r |-> media_lba == last_r || media_lba == last_r + 1'h1)
    else $error("media address did not advance by one sector");
  a_mult_stored: assert property (take && cmd_opcode == OP_SET_MULT |-> ##2 (irq && !busy && !err))
    else $error("block size command did not complete");
  a_err_holds: assert property (!take && !busy |=> $stable(err_code))
    else $error("error code changed while idle");
  a_buf_only: assert property (buf_we |-> !media_we)
    else $error("buffer write reached the media");
  a_drq_in_busy: assert property (drq |-> busy)
    else $error("data request outside a command");
  c_standby: cover property (take && cmd_opcode == OP_STANDBY_NOW);
  c_multiple: cover property (take && cmd_opcode == OP_WRITE_MULT);
  c_idnf: cover property (err && err_code == ERR_IDNF);
endmodule : awc_decoder_monitor
bind awc_decoder awc_decoder_monitor u_mon (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_opcode(cmd_opcode), .cmd_lba(cmd_lba), .busy(busy), .drq(drq), .irq(irq), .err(err),
  .err_code(err_code), .standby(standby), .media_we(media_we), .media_lba(media_lba),
  .buf_we(buf_we));
`default_nettype wire

/* awc_host_model.sv */
// Host-side model: streams counting words while the decoder requests data, answers verifies.
// Assumes inputs sampled on the rising edge; it drives only on falling edges.
`timescale 1ns/1ps
`default_nettype none
module awc_host_model #(
  parameter int DATA_W = 16
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              slow,
  input  wire logic              busy,
  input  wire logic              drq,
  input  wire logic              dma_mode,
  input  wire logic              host_ready,
  input  wire logic              vfy_req,
  output var logic               host_valid,
  output var logic [DATA_W-1:0]  host_data,
  output var logic               vfy_ok
);
  logic              took;
  logic              phase;
  logic [DATA_W-1:0] word;
  initial begin
    took = 1'h0; phase = 1'h0; word = '0;
    host_valid = 1'h0; host_data = '1; vfy_ok = 1'h0;
  end
  always @(posedge clock) took <= host_valid & host_ready;
  // An offered word stays put until taken; idle data is inverted so stale values never match.
  always @(negedge clock) begin : drive
    logic go;
    if (took) word = word + 1'h1;
    go = busy & (drq | dma_mode) & (!slow | phase);
    phase <= ~phase;
    vfy_ok <= vfy_req | (vfy_ok & busy);
    if (rst || !busy) host_valid <= 1'h0;
    else if (!host_valid || took) host_valid <= go;
    if (!host_valid || took || !busy) host_data <= go ? word : ~word;
  end
endmodule : awc_host_model
`default_nettype wire

/* awc_decoder_tb.sv */
// Self-checking bench for the command decoder with a host model on the data side.
// Assumes the decoder's package and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module awc_decoder_tb;
  import awc_pkg::*;
  logic clock, rst, cmd_valid, host_valid, host_ready, busy, drq, dma_mode, irq, err;
  logic standby, media_we, buf_we, vfy_req, vfy_ok, slow;
  logic [7:0]  cmd_opcode, err_code, buf_addr, last_buf;
  logic [15:0] cmd_count, host_data, media_data, buf_data, last_sent, last_bdata, last_mdata;
  logic [47:0] cmd_lba, media_lba, first_lba, last_lba;
  int mismatches, check_count, n_irq, n_we, n_buf, n_vfy;
  awc_decoder DUT (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_count(cmd_count), .cmd_lba(cmd_lba), .host_data(host_data), .host_valid(host_valid),
    .host_ready(host_ready), .busy(busy), .drq(drq), .dma_mode(dma_mode), .irq(irq), .err(err),
    .err_code(err_code), .standby(standby), .media_we(media_we), .media_lba(media_lba),
    .media_data(media_data), .buf_we(buf_we), .buf_addr(buf_addr), .buf_data(buf_data),
    .vfy_req(vfy_req), .vfy_ok(vfy_ok));
  awc_host_model host (.clock(clock), .rst(rst), .slow(slow), .busy(busy), .drq(drq),
    .dma_mode(dma_mode), .host_ready(host_ready), .vfy_req(vfy_req), .host_valid(host_valid),
    .host_data(host_data), .vfy_ok(vfy_ok));
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (irq === 1'h1) n_irq++;
    if (vfy_req === 1'h1) n_vfy++;
    if (host_valid === 1'h1 && host_ready === 1'h1) last_sent = host_data;
    if (buf_we === 1'h1) begin
      last_buf = buf_addr;
      last_bdata = buf_data;
      n_buf++;
    end
    if (media_we === 1'h1) begin
      last_mdata = media_data;
      if (n_we == 0) first_lba = media_lba;
      last_lba = media_lba;
      n_we++;
    end
  end
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic run(input logic [7:0] op, input logic [15:0] cnt, input logic [47:0] lba);
    int i;
    @(negedge clock);
    n_irq = 0; n_we = 0; n_buf = 0; n_vfy = 0;
    cmd_valid = 1'h1; cmd_opcode = op; cmd_count = cnt; cmd_lba = lba;
    @(negedge clock);
    cmd_valid = 1'h0;
    for (i = 0; i < 9000 && busy !== 1'h0; i++) @(negedge clock);
    check("command finished", 48'(i < 9000), 48'h1);
    repeat (3) @(negedge clock);
  endtask : run
  task automatic t_standby;
    run(OP_STANDBY_NOW, 16'h0000, 48'h0);
    check("standby", 48'(standby), 48'h1);
    check("standby irq", 48'(n_irq), 48'h1);
    $display("standby test done");
  endtask : t_standby
  task automatic t_abort;
    run(8'h5A, 16'h0001, 48'h0);
    check("abort code", 48'(err_code), 48'(ERR_ABORT));
    check("abort words", 48'(n_we + n_irq), 48'h1);
    $display("abort test done");
  endtask : t_abort
  task automatic t_sectors;
    run(OP_WRITE_SECT, 16'h0002, 48'h100);
    check("first lba", first_lba, 48'h100);
    check("last lba", last_lba, 48'h101);
    check("sector irqs", 48'(n_irq), 48'h2);
    check("sector words", 48'(n_we), 48'h200);
    check("media data", 48'(last_mdata), 48'(last_sent));
    $display("sector test done");
  endtask : t_sectors
  task automatic t_family;
    logic [7:0] ops [6];
    ops = '{OP_WRITE_DMA_A, OP_WRITE_DMA_B, OP_WRITE_DMA_X, OP_WRITE_SECTX, OP_WRITE_NOERS,
      OP_WRITE_MULTX};
    foreach (ops[k]) begin
      run(ops[k], 16'h0001, 48'h40);
      check("family words", 48'(n_we), 48'h100);
      check("family irqs", 48'(n_irq), 48'h1);
      check("family dma", 48'(dma_mode), 48'(k < 3));
    end
    $display("write family test done");
  endtask : t_family
  task automatic t_multiple;
    slow = 1'h1;
    run(OP_SET_MULT, 16'h0002, 48'h0);
    run(OP_WRITE_MULT, 16'h0004, 48'h200);
    slow = 1'h0;
    check("block irqs", 48'(n_irq), 48'h2);
    check("block words", 48'(n_we), 48'h400);
    $display("multiple test done");
  endtask : t_multiple
  task automatic t_verify_buffer;
    run(OP_WRITE_VFY, 16'h0001, 48'h8);
    check("verify requests", 48'(n_vfy), 48'h1);
    run(OP_WRITE_BUF, 16'h0000, 48'h0);
    check("buffer words", 48'(n_buf), 48'h100);
    check("buffer last", 48'(last_buf), 48'hFF);
    check("buffer data", 48'(last_bdata), 48'(last_sent));
    check("buffer media", 48'(n_we), 48'h0);
    $display("verify and buffer test done");
  endtask : t_verify_buffer
  task automatic t_max;
    run(OP_SET_MAX, 16'h0000, 48'h10);
    run(OP_WRITE_SECT, 16'h0001, 48'h20);
    check("past max code", 48'(err_code), 48'(ERR_IDNF));
    check("past max words", 48'(n_we), 48'h0);
    run(OP_WRITE_SECT, 16'h0001, 48'h8);
    check("below max words", 48'(n_we), 48'h100);
    $display("max address test done");
  endtask : t_max
  // A zero count asks for more sectors than the run can afford, so two are seen and reset ends it.
  task automatic t_zero_count(input logic [7:0] op, input int irqs);
    int i;
    @(negedge clock);
    n_irq = 0; n_we = 0;
    cmd_valid = 1'h1; cmd_opcode = op; cmd_count = 16'h0000; cmd_lba = 48'h300;
    @(negedge clock);
    cmd_valid = 1'h0;
    for (i = 0; i < 2000 && n_we < 512; i++) @(negedge clock);
    check("zero count busy", 48'(busy), 48'h1);
    check("zero count irqs", 48'(n_irq), 48'(irqs));
    rst = 1'h1;
    repeat (2) @(negedge clock);
    rst = 1'h0;
    @(negedge clock);
    check("reset idle", 48'(busy | drq | irq | err), 48'h0);
    $display("zero count test done");
  endtask : t_zero_count
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    #(20 * 30000);
    mismatches++;
    complete_run();
  end
  initial begin
    rst = 1'h1; cmd_valid = 1'h0; cmd_opcode = 8'h00; cmd_count = 16'h0000;
    cmd_lba = 48'h0; slow = 1'h0;
    repeat (2) @(negedge clock);
    rst = 1'h0;
    t_standby();
    t_abort();
    t_sectors();
    t_family();
    t_multiple();
    t_verify_buffer();
    t_zero_count(OP_WRITE_SECT, 2);
    t_zero_count(OP_WRITE_DMA_X, 0);
    t_max();
    complete_run();
  end
endmodule : awc_decoder_tb
`default_nettype wire
